// [sys_call_pkg.sv]
// Shared constants and the return-word helper of the system call handler and its requester.
//
// Notes on behaviour
// - Opcode 0C reloads flash trim for mode.
// - Requester sets bit 1 high for ultra-low-power.
// - Mode switch lasts 20 us, flash reads stalled.
// - Bit 0 chooses word or block parameters.
// - Requester gives aligned block address, all bits.
// - Return word: status 31:28, code 23:0.
// - Status goes to word or block word 0.
// - Basic hash: h = (2h + byte) mod 127.
// - Opcode 0D hashes; type 01 selects CRC8.
// - Requester puts start at 04, count-1 at 08.
// - Hash outside flash returns invalid-address status.
// - Hash reads carry the caller's protection context.
// - Hash value returned in bits 7:0, bits 23:8 zero.
// - Opcode 0E fills start through end inclusive.
// - Requester puts start 04, end 08, data 0C.
// - Fill never touches protected space or flash.
// - Requester aligns fill start and end addresses.
// - Fill start not below end gives status F.
package sys_call_pkg;

	// ----------------------------------------------------------------
	// Call word layout and opcodes
	// ----------------------------------------------------------------
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 24;
	localparam int TYPE_HI = 15;
	localparam int TYPE_LO = 8;
	localparam int MODE_BIT = 1;
	localparam int IN_DATA_BIT = 0;
	localparam logic [7:0] OPC_POWER_SWITCH = 8'h0C;
	localparam logic [7:0] OPC_HASH = 8'h0D;
	localparam logic [7:0] OPC_FILL = 8'h0E;
	localparam logic [7:0] HASH_TYPE_CRC = 8'h01;

	// ----------------------------------------------------------------
	// Parameter block: word index times word size gives the byte offset
	// ----------------------------------------------------------------
	localparam logic [31:0] WORD_BYTES = 32'h00000004;
	localparam logic [1:0] IDX_OP = 2'h0;
	localparam logic [1:0] IDX_START = 2'h1;
	localparam logic [1:0] IDX_END = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;

	// ----------------------------------------------------------------
	// Return word
	// ----------------------------------------------------------------
	localparam logic [3:0] ST_OK = 4'hA;
	localparam logic [3:0] ST_FAIL = 4'hF;
	localparam logic [23:0] ERR_NONE = 24'h000000;
	localparam logic [23:0] ERR_ADDR = 24'h000001;
	localparam logic [23:0] ERR_ARG = 24'h000002;
	localparam logic [23:0] ERR_OPCODE = 24'h000003;
	localparam logic [23:0] ERR_BUS = 24'h000004;
	localparam logic [15:0] HASH_PAD = 16'h0000;
	localparam logic [3:0] RET_UNUSED = 4'h0;

	// ----------------------------------------------------------------
	// Hash constants
	// ----------------------------------------------------------------
	localparam logic [8:0] HASH_MOD = 9'h07F;
	localparam logic [7:0] HASH_INIT = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_XOR_OUT = 8'hFF;

	// ----------------------------------------------------------------
	// Timing at the 40 MHz system clock
	// ----------------------------------------------------------------
	localparam int SWITCH_TIME_NS = 20000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SWITCH_CYCLES = SWITCH_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Requester register map and masters
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CALL = 4'h0;
	localparam logic [3:0] REG_MASTER = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RESULT = 4'hC;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam logic [1:0] MASTER_DEBUG = 2'h0;
	localparam logic [1:0] MASTER_SECURE = 2'h1;
	localparam logic [1:0] MASTER_APP = 2'h2;

	// Builds a return word; bits 27:24 are left at zero.
	function automatic logic [31:0] make_ret(input logic [3:0] st, input logic [23:0] code);
		make_ret = {st, RET_UNUSED, code};
	endfunction

endpackage

// [sys_call_if.sv]
// Link between a requesting master and the system call handler.
`timescale 1ns/1ps
`default_nettype none
interface sys_call_if;
	logic call_valid;
	logic [31:0] call_word;
	logic [1:0] call_master;
	logic call_busy;
	logic ret_valid;
	logic [31:0] ret_word;
	logic ret_to_data;

	modport requester
	(
		output call_valid,
		output call_word,
		output call_master,
		input call_busy,
		input ret_valid,
		input ret_word,
		input ret_to_data
	);

	modport handler
	(
		input call_valid,
		input call_word,
		input call_master,
		output call_busy,
		output ret_valid,
		output ret_word,
		output ret_to_data
	);
endinterface
`default_nettype wire

// [hash_byte_step.sv]
// One byte step of the basic modulo hash or of the CRC8.
`timescale 1ns/1ps
`default_nettype none
module hash_byte_step
	import sys_call_pkg::*;
(
	input wire logic [7:0] acc,
	input wire logic [7:0] data,
	input wire logic crc_sel,
	output logic [7:0] acc_next
);

	logic [8:0] sum;
	logic [7:0] crc;

	// ----------------------------------------------------------------
	// Byte step
	// ----------------------------------------------------------------
	// The running basic hash stays below 127, so twice it plus a byte fits nine bits.
	always_comb
	begin
		sum = {acc, 1'b0} + {1'b0, data};
		crc = acc ^ data;
		for (int i = 0; i < 8; i++)
		begin
			crc = crc[7] ? ({crc[6:0], 1'b0} ^ CRC_POLY) : {crc[6:0], 1'b0};
		end
		acc_next = crc_sel ? crc : 8'(sum % HASH_MOD);
	end

endmodule
`default_nettype wire

// [sys_call_handler.sv]
// Device end: decodes and runs the power switch, hash and bulk fill calls.
`timescale 1ns/1ps
`default_nettype none
module sys_call_handler
	import sys_call_pkg::*;
#(
	parameter logic [31:0] FLASH_BASE = 32'h10000000,
	parameter logic [31:0] FLASH_SIZE = 32'h00080000,
	parameter logic [31:0] WRITE_BASE = 32'h08000000,
	parameter logic [31:0] WRITE_SIZE = 32'h00040000
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	sys_call_if.handler link,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [1:0] mem_prot,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic mem_err,
	output logic fm_reload,
	output logic fm_ulp,
	output logic flash_stall
);

	typedef enum logic [2:0] {S_IDLE, S_PARAM, S_DECODE, S_POWER, S_HASH, S_FILL, S_WB, S_RET} state_t;

	typedef struct packed {
		state_t state;
		logic busy;
		logic in_data;
		logic [1:0] master;
		logic [31:0] ptr;
		logic [1:0] idx;
		logic [3:0][31:0] prm;
		logic [31:0] addr;
		logic [31:0] cnt;
		logic [7:0] hash;
		logic crc;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic fm_reload;
		logic fm_ulp;
		logic stall;
		logic ret_valid;
		logic [31:0] ret_word;
		logic ret_to_data;
	} handler_t;

	handler_t q;
	handler_t n;
	logic fin;
	logic [3:0] fin_st;
	logic [23:0] fin_code;
	logic [7:0] hash_next;
	logic [7:0] op_now;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Last parameter word needed by an opcode; the power switch needs only word 0.
	function automatic logic [1:0] param_last(input logic [7:0] op);
		unique case (op)
			OPC_HASH: param_last = IDX_END;
			OPC_FILL: param_last = IDX_DATA;
			default: param_last = IDX_OP;
		endcase
	endfunction

	// True when lo..hi lies inside base..base+size; 33 bits keep the sum from wrapping.
	function automatic logic in_window(input logic [32:0] lo, input logic [32:0] hi,
		input logic [31:0] base, input logic [31:0] size);
		in_window = (lo >= {1'b0, base}) && (hi < ({1'b0, base} + {1'b0, size}));
	endfunction

	// Aligned word address holding a byte.
	function automatic logic [31:0] word_of(input logic [31:0] a);
		word_of = {a[31:2], 2'b00};
	endfunction

	// Little-endian byte lane select.
	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] sel);
		byte_of = 8'(w >> {sel, 3'b000});
	endfunction

	// ----------------------------------------------------------------
	// Hash datapath
	// ----------------------------------------------------------------
	hash_byte_step u_step
	(
		.acc(q.hash),
		.data(byte_of(mem_rdata, q.addr[1:0])),
		.crc_sel(q.crc),
		.acc_next(hash_next)
	);

	// ----------------------------------------------------------------
	// Call sequencer
	// ----------------------------------------------------------------
	// Only the documented fields are ever decoded, so unused bits cannot steer a call.
	always_comb
	begin
		n = q;
		n.fm_reload = 1'b0;
		n.ret_valid = 1'b0;
		fin = 1'b0;
		fin_st = ST_OK;
		fin_code = ERR_NONE;
		op_now = q.prm[IDX_OP][OPC_HI:OPC_LO];
		unique case (q.state)
			S_IDLE:
			begin
				if (link.call_valid)
				begin
					n.busy = 1'b1;
					n.master = link.call_master;
					n.in_data = link.call_word[IN_DATA_BIT];
					n.ptr = link.call_word;
					n.idx = IDX_OP;
					n.prm[IDX_OP] = link.call_word;
					if (link.call_word[IN_DATA_BIT])
					begin
						n.state = S_DECODE;
					end
					else
					begin
						n.state = S_PARAM;
						n.mem_req = 1'b1;
						n.mem_we = 1'b0;
						n.mem_addr = link.call_word;
					end
				end
			end
			S_PARAM:
			begin
				// Parameter words are read in order; the opcode in word 0 says how many follow.
				if (mem_ack)
				begin
					n.prm[q.idx] = mem_rdata;
					if (mem_err)
					begin
						n.mem_req = 1'b0;
						fin = 1'b1;
						fin_st = ST_FAIL;
						fin_code = ERR_BUS;
					end
					else if (q.idx >= param_last((q.idx == IDX_OP) ? mem_rdata[OPC_HI:OPC_LO] : op_now))
					begin
						n.mem_req = 1'b0;
						n.state = S_DECODE;
					end
					else
					begin
						n.idx = q.idx + 2'h1;
						n.mem_addr = q.mem_addr + WORD_BYTES;
					end
				end
			end
			S_DECODE:
			begin
				if (op_now == OPC_POWER_SWITCH)
				begin
					n.fm_reload = 1'b1;
					n.fm_ulp = q.prm[IDX_OP][MODE_BIT];
					n.stall = 1'b1;
					n.cnt = 32'(SWITCH_CYCLES - 1);
					n.state = S_POWER;
				end
				else if (q.in_data)
				begin
					// Only the power switch may carry its arguments in the call word.
					fin = 1'b1;
					fin_st = ST_FAIL;
					fin_code = ERR_OPCODE;
				end
				else if (op_now == OPC_HASH)
				begin
					if (in_window({1'b0, q.prm[IDX_START]}, {1'b0, q.prm[IDX_START]} + {1'b0, q.prm[IDX_END]},
						FLASH_BASE, FLASH_SIZE))
					begin
						n.crc = (q.prm[IDX_OP][TYPE_HI:TYPE_LO] == HASH_TYPE_CRC);
						n.hash = n.crc ? CRC_INIT : HASH_INIT;
						n.addr = q.prm[IDX_START];
						n.cnt = q.prm[IDX_END];
						n.mem_req = 1'b1;
						n.mem_we = 1'b0;
						n.mem_addr = word_of(q.prm[IDX_START]);
						n.state = S_HASH;
					end
					else
					begin
						fin = 1'b1;
						fin_st = ST_FAIL;
						fin_code = ERR_ADDR;
					end
				end
				else if (op_now == OPC_FILL)
				begin
					// Every check is settled here, before any write is issued.
					if (q.prm[IDX_START] >= q.prm[IDX_END])
					begin
						fin = 1'b1;
						fin_st = ST_FAIL;
						fin_code = ERR_ARG;
					end
					else if (q.prm[IDX_START][1:0] != 2'b00 || q.prm[IDX_END][1:0] != 2'b00 ||
						!in_window({1'b0, q.prm[IDX_START]}, {1'b0, q.prm[IDX_END]}, WRITE_BASE, WRITE_SIZE))
					begin
						fin = 1'b1;
						fin_st = ST_FAIL;
						fin_code = ERR_ADDR;
					end
					else
					begin
						n.mem_req = 1'b1;
						n.mem_we = 1'b1;
						n.mem_addr = q.prm[IDX_START];
						n.mem_wdata = q.prm[IDX_DATA];
						n.state = S_FILL;
					end
				end
				else
				begin
					fin = 1'b1;
					fin_st = ST_FAIL;
					fin_code = ERR_OPCODE;
				end
			end
			S_POWER:
			begin
				// Flash reads stay stalled until the count runs out.
				if (q.cnt == 32'h00000000)
				begin
					n.stall = 1'b0;
					fin = 1'b1;
				end
				else
				begin
					n.cnt = q.cnt - 32'h00000001;
				end
			end
			S_HASH:
			begin
				// One read per byte keeps the datapath small at the cost of speed.
				if (mem_ack)
				begin
					n.hash = hash_next;
					if (mem_err)
					begin
						n.mem_req = 1'b0;
						fin = 1'b1;
						fin_st = ST_FAIL;
						fin_code = ERR_BUS;
					end
					else if (q.cnt == 32'h00000000)
					begin
						n.mem_req = 1'b0;
						fin = 1'b1;
						fin_code = {HASH_PAD, q.crc ? (hash_next ^ CRC_XOR_OUT) : hash_next};
					end
					else
					begin
						n.cnt = q.cnt - 32'h00000001;
						n.addr = q.addr + 32'h00000001;
						n.mem_addr = word_of(q.addr + 32'h00000001);
					end
				end
			end
			S_FILL:
			begin
				if (mem_ack)
				begin
					if (mem_err || q.mem_addr == q.prm[IDX_END])
					begin
						n.mem_req = 1'b0;
						n.mem_we = 1'b0;
						fin = 1'b1;
						fin_st = mem_err ? ST_FAIL : ST_OK;
						fin_code = mem_err ? ERR_BUS : ERR_NONE;
					end
					else
					begin
						n.mem_addr = q.mem_addr + WORD_BYTES;
					end
				end
			end
			S_WB:
			begin
				if (mem_ack)
				begin
					n.mem_req = 1'b0;
					n.mem_we = 1'b0;
					n.state = S_RET;
				end
			end
			S_RET:
			begin
				n.ret_valid = 1'b1;
				n.ret_to_data = q.in_data;
				n.busy = 1'b0;
				n.state = S_IDLE;
			end
		endcase

		// Every call ends here: the word goes straight back or first to block word 0.
		if (fin)
		begin
			n.ret_word = make_ret(fin_st, fin_code);
			if (q.in_data)
			begin
				n.state = S_RET;
			end
			else
			begin
				n.state = S_WB;
				n.mem_req = 1'b1;
				n.mem_we = 1'b1;
				n.mem_addr = q.ptr;
				n.mem_wdata = make_ret(fin_st, fin_code);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// All-zero is idle with every strobe low.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every access carries the caller's master id as its protection context.
	assign mem_prot = q.master;
	assign mem_req = q.mem_req;
	assign mem_we = q.mem_we;
	assign mem_addr = q.mem_addr;
	assign mem_wdata = q.mem_wdata;
	assign fm_reload = q.fm_reload;
	assign fm_ulp = q.fm_ulp;
	assign flash_stall = q.stall;
	assign link.call_busy = q.busy;
	assign link.ret_valid = q.ret_valid;
	assign link.ret_word = q.ret_word;
	assign link.ret_to_data = q.ret_to_data;

endmodule
`default_nettype wire

// [sys_call_requester.sv]
// Requesting end: software registers that issue calls and collect results.
`timescale 1ns/1ps
`default_nettype none
module sys_call_requester
	import sys_call_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	sys_call_if.requester link,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	typedef struct packed {
		logic call_valid;
		logic [31:0] call_word;
		logic [1:0] master;
		logic done;
		logic [31:0] result;
		logic [31:0] rdata;
	} requester_t;

	requester_t q;
	requester_t n;
	logic busy;

	// ----------------------------------------------------------------
	// Register port and call issue
	// ----------------------------------------------------------------
	// A call word written while a call runs is dropped, so a running call never sees its word change.
	always_comb
	begin
		n = q;
		n.call_valid = 1'b0;
		n.rdata = 32'h00000000;
		busy = link.call_busy | q.call_valid;
		if (reg_wr && reg_addr == REG_CALL && !busy)
		begin
			n.call_word = reg_wdata;
			n.call_valid = 1'b1;
			n.done = 1'b0;
		end
		if (reg_wr && reg_addr == REG_MASTER)
		begin
			n.master = reg_wdata[1:0];
		end
		// The return sets done after any clear above, so the set wins.
		if (link.ret_valid)
		begin
			n.done = 1'b1;
			n.result = link.ret_word;
			if (link.ret_to_data)
			begin
				n.call_word = link.ret_word;
			end
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				REG_CALL: n.rdata = q.call_word;
				REG_MASTER: n.rdata = {30'h00000000, q.master};
				REG_STATUS:
				begin
					// Bits are placed one by one, so no shift can lose them to a narrow width.
					n.rdata[STAT_DONE] = q.done;
					n.rdata[STAT_BUSY] = busy;
				end
				REG_RESULT: n.rdata = q.result;
				default: n.rdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = q.rdata;
	assign link.call_valid = q.call_valid;
	assign link.call_word = q.call_word;
	assign link.call_master = q.master;

endmodule
`default_nettype wire

// [sys_call_props.sv]
// Concurrent checks on the link that joins the requester and the system call handler.
`timescale 1ns/1ps
`default_nettype none
module sys_call_props
	import sys_call_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic call_valid,
	input wire logic [31:0] call_word,
	input wire logic [1:0] call_master,
	input wire logic call_busy,
	input wire logic ret_valid,
	input wire logic [31:0] ret_word,
	input wire logic ret_to_data
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ----
	// Call tracking
	// ----
	logic [7:0] op_q;
	logic dir_q;
	logic act_q;
	logic [10:0] cnt_q;

	// The call word may be overwritten by the returned word, so form and top byte are latched at acceptance.
	// The top byte is the opcode only in the direct form; in the block form it is part of the pointer.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			op_q <= 8'h00;
			dir_q <= 1'b0;
			act_q <= 1'b0;
			cnt_q <= 11'h000;
		end
		else if (call_valid && !call_busy && !act_q)
		begin
			op_q <= call_word[31:24];
			dir_q <= call_word[0];
			act_q <= 1'b1;
			cnt_q <= 11'h000;
		end
		else
		begin
			if (ret_valid)
				act_q <= 1'b0;
			if (act_q && cnt_q != 11'h7FF)
				cnt_q <= cnt_q + 11'h001;
		end
	end

	// ----
	// Assertions
	// ----
	pulse_valid_a: assert property (call_valid |=> !call_valid) else $error("call_valid longer than one cycle");
	busy_set_a: assert property (call_valid && !call_busy && !act_q |=> call_busy) else $error("busy not raised");
	busy_hold_a: assert property (act_q && !ret_valid |-> call_busy) else $error("busy dropped early");
	busy_drop_a: assert property (ret_valid |=> !call_busy) else $error("busy stays after return");
	ret_cause_a: assert property (ret_valid |-> act_q) else $error("return without call");
	status_code_a: assert property (ret_valid |-> ret_word[31:28] == ST_OK || ret_word[31:28] == ST_FAIL)
		else $error("bad status nibble");
	unused_bits_a: assert property (ret_valid |-> ret_word[27:24] == 4'h0) else $error("bits 27:24 set");
	ret_place_a: assert property (ret_valid |-> ret_to_data == dir_q) else $error("status placed wrongly");
	switch_time_a: assert property (ret_valid && dir_q && op_q == OPC_POWER_SWITCH |->
		cnt_q >= 11'h320 && cnt_q <= 11'h32F) else $error("switch time off");
	switch_ok_a: assert property (ret_valid && dir_q && op_q == OPC_POWER_SWITCH |->
		ret_word == {ST_OK, 4'h0, ERR_NONE}) else $error("switch not successful");
	direct_other_a: assert property (ret_valid && dir_q && op_q != OPC_POWER_SWITCH |->
		ret_word == {ST_FAIL, 4'h0, ERR_OPCODE}) else $error("direct form accepted");

	// Main scenarios.
	direct_c: cover property (ret_valid && dir_q);
	block_ok_c: cover property (ret_valid && !dir_q && ret_word[31:28] == ST_OK);
	block_fail_c: cover property (ret_valid && !dir_q && ret_word[31:28] == ST_FAIL);
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench: requester and handler joined by their link, with a memory model.
`timescale 1ns/1ps
`default_nettype none
module tb
	import sys_call_pkg::*;
;
	localparam logic [31:0] FB = 32'h10000000;
	localparam logic [31:0] FS = 32'h00080000;
	localparam logic [31:0] WB = 32'h08000000;
	localparam logic [31:0] P = 32'h08000100;
	localparam logic [31:0] BAD = 32'h08000200;
	logic clk_sys, resetn, reg_wr, reg_rd, mem_req, mem_we, mem_ack, mem_err, fm_reload, fm_ulp, flash_stall;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [1:0] mem_prot, cur_master;
	logic [31:0] mem [logic [31:0]];
	int err_total, comparisons, stall_n, rl_n, wr_n, prot_bad;

	sys_call_if link();
	sys_call_requester i_sys_call_requester(.clk_sys(clk_sys), .resetn(resetn), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sys_call_handler #(.FLASH_BASE(FB), .FLASH_SIZE(FS), .WRITE_BASE(WB), .WRITE_SIZE(32'h00040000)) i_sys_call_handler(
		.clk_sys(clk_sys), .resetn(resetn), .link(link), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_prot(mem_prot), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
		.fm_reload(fm_reload), .fm_ulp(fm_ulp), .flash_stall(flash_stall));
	sys_call_props i_sys_call_props(.clk_sys(clk_sys), .resetn(resetn), .call_valid(link.call_valid),
		.call_word(link.call_word), .call_master(link.call_master), .call_busy(link.call_busy),
		.ret_valid(link.ret_valid), .ret_word(link.ret_word), .ret_to_data(link.ret_to_data));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ----
	// Memory model and monitors
	// ----
	function automatic logic [7:0] bv(input logic [31:0] a);
		bv = a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	function automatic logic [31:0] rdw(input logic [31:0] a);
		logic [31:0] w;
		w = {a[31:2], 2'h0};
		rdw = mem.exists(w) ? mem[w] : {bv(w + 32'h3), bv(w + 32'h2), bv(w + 32'h1), bv(w)};
	endfunction

	// Idle read data toggles so that a stale sample never looks valid; one address answers with a fault.
	always @(posedge clk_sys)
	begin
		if (flash_stall === 1'b1)
			stall_n++;
		if (fm_reload === 1'b1)
			rl_n++;
		if (!resetn)
		begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h0;
		end
		else if (mem_req === 1'b1 && !mem_ack)
		begin
			mem_ack <= 1'b1;
			mem_err <= (mem_addr == BAD);
			if (mem_prot !== cur_master)
				prot_bad++;
			if (mem_we)
			begin
				mem[mem_addr] = mem_wdata;
				wr_n++;
				mem_rdata <= ~mem_rdata;
			end
			else
				mem_rdata <= rdw(mem_addr);
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic call(input logic [1:0] m, input logic [31:0] w, output logic [31:0] r);
		logic [31:0] s;
		int i;
		cur_master = m;
		s = 32'h0;
		wr(REG_MASTER, {30'h0, m});
		wr(REG_CALL, w);
		for (i = 0; i < 1000 && s[STAT_DONE] !== 1'b1; i++)
			rd(REG_STATUS, s);
		chk({31'h0, s[STAT_DONE]}, 32'h1, "call done");
		rd(REG_RESULT, r);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	// Unused bits are set on purpose; the block form leaves its pointer in the call word.
	task automatic t_power(input logic dir, input logic ultra_low_power_mode);
		logic [31:0] w, r;
		int s0, r0;
		w = {OPC_POWER_SWITCH, 22'h3FFFFF, ultra_low_power_mode, 1'b1};
		s0 = stall_n;
		r0 = rl_n;
		if (!dir)
		begin
			mem[P] = w;
			w = P;
		end
		call(MASTER_DEBUG, w, r);
		chk(r, {ST_OK, 4'h0, ERR_NONE}, "switch result");
		chk({31'h0, fm_ulp}, {31'h0, ultra_low_power_mode}, "mode");
		chk(32'(rl_n - r0), 32'h1, "trim reloads");
		chk(32'(stall_n - s0), 32'h00000320, "stall cycles");
		if (dir)
			rd(REG_CALL, w);
		else
			w = mem[P];
		chk(w, r, "status placement");
		$display("test power switch done");
	endtask
	task automatic t_hash(input logic [7:0] ty, input logic [1:0] m, input logic [31:0] a, input int n, input logic ok);
		logic [31:0] r;
		int h, c, i, k, b, p0;
		mem[P] = {OPC_HASH, 8'hA5, ty, 8'h5A};
		mem[P + 32'h4] = a;
		mem[P + 32'h8] = 32'(n - 1);
		h = 0;
		c = 8'hFF;
		for (i = 0; i < n; i++)
		begin
			b = bv(a + 32'(i));
			h = (h * 2 + b) % 127;
			c = c ^ b;
			for (k = 0; k < 8; k++)
				c = (c & 8'h80) ? ((c << 1) ^ 8'h1D) & 8'hFF : (c << 1) & 8'hFF;
		end
		if (ty == HASH_TYPE_CRC)
			h = c ^ 8'hFF;
		p0 = prot_bad;
		call(m, P, r);
		chk(r, ok ? {ST_OK, 4'h0, 16'h0, 8'(h)} : {ST_FAIL, 4'h0, ERR_ADDR}, "hash");
		chk(32'(prot_bad - p0), 32'h0, "protection context");
		chk(mem[P], r, "status in block");
		$display("test hash done");
	endtask
	task automatic t_fill(input logic [31:0] s, input logic [31:0] e, input logic [23:0] code);
		logic [31:0] r, a;
		int w0;
		mem.delete();
		mem[P] = {OPC_FILL, 24'hC3C3C3};
		mem[P + 32'h4] = s;
		mem[P + 32'h8] = e;
		mem[P + 32'hC] = 32'h5AA50FF0;
		w0 = wr_n;
		call(MASTER_APP, P, r);
		chk(r, {(code == ERR_NONE) ? ST_OK : ST_FAIL, 4'h0, code}, "fill result");
		chk(32'(wr_n - w0), (code == ERR_NONE) ? (e - s) / 32'h4 + 32'h2 : 32'h1, "write count");
		for (a = s - 32'h4; a <= e + 32'h4; a += 32'h4)
			chk(mem.exists(a) ? mem[a] : 32'h0, (code == ERR_NONE && a >= s && a <= e) ? 32'h5AA50FF0 : 32'h0, "word");
		$display("test fill done");
	endtask

	initial
	begin
		logic [31:0] r;
		{resetn, reg_wr, reg_rd} = 3'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		cur_master = 2'h0;
		{err_total, comparisons} = {2{32'sd0}};
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		t_power(1'b1, 1'b1);
		t_power(1'b1, 1'b0);
		t_power(1'b0, 1'b1);
		t_hash(HASH_TYPE_CRC, MASTER_SECURE, FB + 32'h1, 6, 1'b1);
		t_hash(8'h05, MASTER_APP, FB + 32'h22, 5, 1'b1);
		t_hash(8'h00, MASTER_DEBUG, FB + FS - 32'h2, 4, 1'b0);
		t_fill(WB + 32'h40, WB + 32'h48, ERR_NONE);
		t_fill(WB + 32'h40, WB + 32'h40, ERR_ARG);
		t_fill(FB, FB + 32'h8, ERR_ADDR);
		t_fill(WB + 32'h3FFF8, WB + 32'h40000, ERR_ADDR);
		t_fill(WB + 32'h42, WB + 32'h48, ERR_ADDR);
		mem[P] = {8'h0B, 24'h000000};
		call(MASTER_APP, P, r);
		chk(r, {ST_FAIL, 4'h0, ERR_OPCODE}, "unknown opcode");
		call(MASTER_APP, BAD, r);
		chk(r, {ST_FAIL, 4'h0, ERR_BUS}, "bus fault");
		call(MASTER_SECURE, {OPC_HASH, 24'h000001}, r);
		chk(r, {ST_FAIL, 4'h0, ERR_OPCODE}, "direct non-switch");
		rd(4'h2, r);
		chk(r, 32'h0, "unmapped read");
		$display("test misc done");
		close_out();
	end

	// Watchdog: the run needs well under 20000 cycles.
	initial
	begin
		#1500000;
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
